// *** include/cmlc_pkg.sv ***
package cmlc_pkg;
  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int NUM_CH = 10;
  localparam int CH_W = 4;
  localparam int RES_W = 10;
  localparam int LIM_W = 8;
  localparam int ACC_W = 14;
  localparam logic [3:0] AVG_LAST = 4'hF;
  localparam logic [7:0] CH_CNT = 8'h0A;
  // ---------------------------------------------------------------
  // channel codes
  // ---------------------------------------------------------------
  localparam logic [3:0] CH_VDD = 4'h0;
  localparam logic [3:0] CH_INT = 4'h1;
  localparam logic [3:0] CH_EXT = 4'h2;
  localparam logic [3:0] CH_AIN3 = 4'h4;
  localparam logic [3:0] CH_LAST = 4'h9;
  // ---------------------------------------------------------------
  // register indices, byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_STAT1 = 8'h00;
  localparam logic [7:0] IDX_STAT2 = 8'h01;
  localparam logic [7:0] IDX_CFG1 = 8'h18;
  localparam logic [7:0] IDX_CTL2 = 8'h19;
  localparam logic [7:0] IDX_MASK1 = 8'h1D;
  localparam logic [7:0] IDX_MASK2 = 8'h1E;
  localparam logic [7:0] IDX_TOFS = 8'h1F;
  localparam logic [7:0] IDX_RES_BASE = 8'h30;
  localparam logic [7:0] IDX_UPPER_BASE = 8'h40;
  localparam logic [7:0] IDX_LOWER_BASE = 8'h50;
  // ---------------------------------------------------------------
  // fields and reset values
  // ---------------------------------------------------------------
  localparam int CFG1_EN_BIT = 0;
  localparam int CFG1_AIN_BIT = 1;
  localparam int CFG1_POL_BIT = 3;
  localparam int CTL2_SINGLE_BIT = 4;
  localparam int CTL2_AVGOFF_BIT = 5;
  localparam int ST2_ANALOG_INPUT_EIGHT_BIT = 0;
  localparam int ST2_VDD_BIT = 4;
  localparam logic [7:0] CFG1_RST = 8'h08;
  localparam logic [7:0] CTL2_RST = 8'h00;
  localparam logic [7:0] TOFS_RST = 8'h00;
  localparam logic [7:0] UPPER_RST = 8'hFF;
  localparam logic [7:0] LOWER_RST = 8'h00;
  typedef enum logic [1:0] {
    SQ_IDLE = 2'b00,
    SQ_CONV = 2'b01,
    SQ_PAUSE = 2'b11
  } cmlc_seq_t;
endpackage

// *** include/cmlc_res_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface cmlc_res_if;
  logic wr_en;
  logic [3:0] wr_ch;
  logic [9:0] wr_data;
  logic [3:0] rd_ch;
  logic [9:0] rd_data;
  logic [7:0] upper;
  logic [7:0] lower;
  logic is_signed;
  logic chk_valid;
  logic [3:0] chk_ch;
  logic chk_over;
  modport ctl(output wr_en, wr_ch, wr_data, rd_ch, upper, lower, is_signed,
              input rd_data, chk_valid, chk_ch, chk_over);
  modport mem(input wr_en, wr_ch, wr_data, rd_ch, output rd_data);
  modport chk(input wr_en, wr_ch, wr_data, upper, lower, is_signed,
              output chk_valid, chk_ch, chk_over);
endinterface
`default_nettype wire

// *** rtl/cmlc_result_mem.sv ***
`timescale 1ns/1ps
`default_nettype none
module cmlc_result_mem
  import cmlc_pkg::*;
#(
  parameter int DEPTH = NUM_CH,
  parameter int WIDTH = RES_W
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  cmlc_res_if.mem bus
);
  generate
    if (DEPTH < 1 || DEPTH > 16 || WIDTH != RES_W) begin : g_bad
      $error("cmlc_result_mem: unsupported depth or width");
    end
  endgenerate

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] word;
    logic [WIDTH-1:0] rd;
  } cmlc_mem_t;

  cmlc_mem_t s;
  cmlc_mem_t next_s;

  always_comb begin
    next_s = s;
    for (int i = 0; i < DEPTH; i++) begin
      if (bus.wr_en && 32'(bus.wr_ch) == i) begin
        next_s.word[i] = bus.wr_data;
      end
    end
    next_s.rd = (32'(bus.rd_ch) < DEPTH) ? s.word[bus.rd_ch] : '0;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign bus.rd_data = s.rd;
endmodule
`default_nettype wire

// *** rtl/cmlc_limit_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module cmlc_limit_chk
  import cmlc_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  cmlc_res_if.chk bus
);
  typedef struct packed {
    logic valid;
    logic [3:0] ch;
    logic over;
  } cmlc_chk_t;

  cmlc_chk_t s;
  cmlc_chk_t next_s;
  logic [LIM_W-1:0] top;
  logic hi;
  logic lo;

  // ---------------------------------------------------------------
  // compare top eight result bits with the limits
  // ---------------------------------------------------------------
  always_comb begin
    top = bus.wr_data[RES_W-1:RES_W-LIM_W];
    if (bus.is_signed) begin
      hi = $signed(top) > $signed(bus.upper);
      lo = $signed(top) <= $signed(bus.lower);
    end else begin
      hi = top > bus.upper;
      lo = top <= bus.lower;
    end
    next_s.valid = bus.wr_en;
    next_s.ch = bus.wr_ch;
    next_s.over = hi || lo;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign bus.chk_valid = s.valid;
  assign bus.chk_ch = s.ch;
  assign bus.chk_over = s.over;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);

  over_upper_a: assert property (bus.wr_en && !bus.is_signed &&
      bus.wr_data[9:2] > bus.upper |=> bus.chk_valid && bus.chk_over)
    else $error("unsigned result above upper limit not flagged");
  within_a: assert property (bus.wr_en && !bus.is_signed &&
      bus.wr_data[9:2] <= bus.upper && bus.wr_data[9:2] > bus.lower |=> !bus.chk_over)
    else $error("in-range result flagged");
endmodule
`default_nettype wire

// *** rtl/cmlc_monitor.sv ***
// What this block does
// - single-channel bit set: convert only the channel the select field names
// - select field zero is supply channel, one is internal temperature
// - single-channel conversions follow each other with no idle gap
// - a register access aborts the conversion; it resumes after the access
// - temperature results are ten-bit twos complement
// - one temperature code step is a quarter degree
// - internal temperature gets the stored offset added before storing
// - with averaging on, external temperature is the mean of sixteen samples
// - out of limit means above upper or at or below lower limit
// - limits are eight bits wide, results ten bits wide
// - an unmasked out-of-limit result sets a status flag
// - interrupt output active, at chosen polarity, while unmasked flags stand
// - averaging on after reset; control bit five turns it off
// - reset leaves round robin with conversions off; config bit zero enables
// - round robin order: supply, internal, external or inputs, inputs three to eight
`timescale 1ns/1ps
`default_nettype none
module cmlc_monitor
  import cmlc_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [9:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_adc_start,
  output logic o_adc_abort,
  output logic [3:0] o_adc_channel,
  input wire logic i_adc_done,
  input wire logic [9:0] i_adc_data,
  output logic o_int
);
  typedef struct packed {
    cmlc_seq_t seq;
    logic [3:0] ch;
    logic [3:0] avg_cnt;
    logic [ACC_W-1:0] acc;
    logic adc_start;
    logic adc_abort;
    logic wr_en;
    logic [3:0] wr_ch;
    logic [9:0] wr_data;
    logic [7:0] cfg1;
    logic [7:0] ctl2;
    logic [7:0] tofs;
    logic [NUM_CH-1:0] mask;
    logic [NUM_CH-1:0] flags;
    logic [NUM_CH-1:0][7:0] upper;
    logic [NUM_CH-1:0][7:0] lower;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
  } cmlc_state_t;

  localparam cmlc_state_t ST_RST = '{
    seq: SQ_IDLE,
    cfg1: CFG1_RST,
    ctl2: CTL2_RST,
    tofs: TOFS_RST,
    upper: {NUM_CH{UPPER_RST}},
    lower: {NUM_CH{LOWER_RST}},
    irq: ~CFG1_RST[CFG1_POL_BIT],
    default: '0
  };

  cmlc_state_t s;
  cmlc_state_t next_s;
  cmlc_res_if res ();

  logic [7:0] idx;
  logic [7:0] off_res;
  logic [7:0] off_up;
  logic [7:0] off_lo;
  logic hit;
  logic [31:0] rdata;
  logic busy;
  logic done_xfer;
  logic en;
  logic ain_mode;
  logic single;
  logic avg_on;
  logic [3:0] sel_ch;
  logic [NUM_CH-1:0] clr;
  logic [NUM_CH-1:0] set;
  logic [9:0] sample;
  logic [ACC_W-1:0] sum;
  logic store;
  logic pending;

  function automatic logic [7:0] st2_byte(input logic [NUM_CH-1:0] v);
    logic [7:0] b;
    b = 8'h00;
    b[ST2_ANALOG_INPUT_EIGHT_BIT] = v[CH_LAST];
    b[ST2_VDD_BIT] = v[CH_VDD];
    return b;
  endfunction

  function automatic logic [3:0] rr_next(input logic [3:0] ch, input logic ain);
    logic [3:0] r;
    r = ch + 4'h1;
    if (ch == CH_LAST) begin
      r = CH_VDD;
    end else if (ch == CH_EXT && !ain) begin
      r = CH_AIN3;
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // submodules
  // ---------------------------------------------------------------
  cmlc_result_mem #(
    .DEPTH(NUM_CH),
    .WIDTH(RES_W)
  ) u_mem (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .bus(res.mem)
  );

  cmlc_limit_chk u_chk (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .bus(res.chk)
  );

  assign res.wr_en = s.wr_en;
  assign res.wr_ch = s.wr_ch;
  assign res.wr_data = s.wr_data;
  assign res.rd_ch = off_res[3:0];
  assign res.upper = s.upper[s.wr_ch];
  assign res.lower = s.lower[s.wr_ch];
  assign res.is_signed = (s.wr_ch == CH_INT) || (s.wr_ch == CH_EXT && !ain_mode);

  // ---------------------------------------------------------------
  // register decode
  // ---------------------------------------------------------------
  always_comb begin
    idx = i_paddr[9:2];
    off_res = idx - IDX_RES_BASE;
    off_up = idx - IDX_UPPER_BASE;
    off_lo = idx - IDX_LOWER_BASE;
    hit = 1'b1;
    rdata = '0;
    case (idx)
      IDX_STAT1: rdata[7:0] = s.flags[8:1];
      IDX_STAT2: rdata[7:0] = st2_byte(s.flags);
      IDX_CFG1: rdata[7:0] = s.cfg1;
      IDX_CTL2: rdata[7:0] = s.ctl2;
      IDX_MASK1: rdata[7:0] = s.mask[8:1];
      IDX_MASK2: rdata[7:0] = st2_byte(s.mask);
      IDX_TOFS: rdata[7:0] = s.tofs;
      default: begin
        if (off_res < CH_CNT) begin
          rdata[9:0] = res.rd_data;
        end else if (off_up < CH_CNT) begin
          rdata[7:0] = s.upper[off_up[3:0]];
        end else if (off_lo < CH_CNT) begin
          rdata[7:0] = s.lower[off_lo[3:0]];
        end else begin
          hit = 1'b0;
        end
      end
    endcase
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.adc_start = 1'b0;
    next_s.adc_abort = 1'b0;
    next_s.wr_en = 1'b0;
    next_s.pready = 1'b0;
    next_s.pslverr = 1'b0;
    busy = i_psel;
    done_xfer = i_psel && i_penable && s.pready;
    en = s.cfg1[CFG1_EN_BIT];
    ain_mode = s.cfg1[CFG1_AIN_BIT];
    single = s.ctl2[CTL2_SINGLE_BIT];
    sel_ch = (s.ctl2[3:0] > CH_LAST) ? CH_VDD : s.ctl2[3:0];
    avg_on = !s.ctl2[CTL2_AVGOFF_BIT] && s.ch == CH_EXT && !ain_mode;
    clr = '0;
    set = '0;
    sample = i_adc_data;
    sum = s.acc + {{(ACC_W-RES_W){i_adc_data[9]}}, i_adc_data};
    store = 1'b0;
    pending = 1'b0;

    if (i_psel && i_penable && !s.pready) begin
      next_s.pready = 1'b1;
      next_s.pslverr = !hit;
      next_s.prdata = (hit && !i_pwrite) ? rdata : '0;
    end

    if (done_xfer && i_pwrite && hit) begin
      case (idx)
        IDX_STAT1: clr[8:1] = i_pwdata[7:0];
        IDX_STAT2: begin
          clr[CH_LAST] = i_pwdata[ST2_ANALOG_INPUT_EIGHT_BIT];
          clr[CH_VDD] = i_pwdata[ST2_VDD_BIT];
        end
        IDX_CFG1: next_s.cfg1 = i_pwdata[7:0];
        IDX_CTL2: next_s.ctl2 = i_pwdata[7:0];
        IDX_MASK1: next_s.mask[8:1] = i_pwdata[7:0];
        IDX_MASK2: begin
          next_s.mask[CH_LAST] = i_pwdata[ST2_ANALOG_INPUT_EIGHT_BIT];
          next_s.mask[CH_VDD] = i_pwdata[ST2_VDD_BIT];
        end
        IDX_TOFS: next_s.tofs = i_pwdata[7:0];
        default: begin
          if (off_up < CH_CNT) begin
            next_s.upper[off_up[3:0]] = i_pwdata[7:0];
          end else if (off_lo < CH_CNT) begin
            next_s.lower[off_lo[3:0]] = i_pwdata[7:0];
          end
        end
      endcase
    end

    // sequencer
    case (s.seq)
      SQ_IDLE: begin
        if (en && !busy) begin
          next_s.seq = SQ_CONV;
          next_s.ch = single ? sel_ch : CH_VDD;
          next_s.adc_start = 1'b1;
          next_s.acc = '0;
          next_s.avg_cnt = '0;
        end
      end
      SQ_CONV: begin
        if (!en || busy) begin
          next_s.adc_abort = 1'b1;
          next_s.seq = en ? SQ_PAUSE : SQ_IDLE;
          next_s.acc = '0;
          next_s.avg_cnt = '0;
        end else if (i_adc_done) begin
          if (s.ch == CH_INT) begin
            sample = i_adc_data + {{2{s.tofs[7]}}, s.tofs};
          end
          if (avg_on && s.avg_cnt != AVG_LAST) begin
            next_s.avg_cnt = s.avg_cnt + 4'h1;
            next_s.acc = sum;
          end else begin
            store = 1'b1;
            if (avg_on) begin
              sample = sum[ACC_W-1:ACC_W-RES_W];
            end
            next_s.avg_cnt = '0;
            next_s.acc = '0;
            next_s.ch = single ? sel_ch : rr_next(s.ch, ain_mode);
          end
          next_s.adc_start = 1'b1;
        end
      end
      SQ_PAUSE: begin
        if (!busy) begin
          next_s.seq = en ? SQ_CONV : SQ_IDLE;
          next_s.adc_start = en;
          next_s.ch = single ? sel_ch : s.ch;
        end
      end
      default: next_s.seq = SQ_IDLE;
    endcase

    if (store) begin
      next_s.wr_en = 1'b1;
      next_s.wr_ch = s.ch;
      next_s.wr_data = sample;
    end

    // flags: a set in the clearing cycle wins
    if (res.chk_valid && res.chk_over && !s.mask[res.chk_ch]) begin
      set[res.chk_ch] = 1'b1;
    end
    next_s.flags = (s.flags & ~clr) | set;
    pending = |(next_s.flags & ~next_s.mask);
    next_s.irq = pending ? next_s.cfg1[CFG1_POL_BIT] : !next_s.cfg1[CFG1_POL_BIT];
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      s <= ST_RST;
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign o_prdata = s.prdata;
  assign o_pready = s.pready;
  assign o_pslverr = s.pslverr;
  assign o_adc_start = s.adc_start;
  assign o_adc_abort = s.adc_abort;
  assign o_adc_channel = s.ch;
  assign o_int = s.irq;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);

  sequence conv_done_s;
    s.seq == SQ_CONV && i_adc_done && !i_psel && en;
  endsequence
  sequence access_hit_s;
    s.seq == SQ_CONV && i_psel && en;
  endsequence
  sequence paused_s;
    (s.seq == SQ_PAUSE && i_psel) ##1 (s.seq == SQ_PAUSE && !i_psel && en);
  endsequence

  no_gap_a: assert property (conv_done_s |=> o_adc_start)
    else $error("no restart right after conversion end");
  abort_on_access_a: assert property (access_hit_s |=> o_adc_abort && !o_adc_start
      ##1 !o_adc_start)
    else $error("access did not abort conversion");
  resume_a: assert property (paused_s |=> o_adc_start && s.seq == SQ_CONV)
    else $error("conversion not resumed after access");
  single_ch_a: assert property (conv_done_s and single |=> o_adc_channel == $past(sel_ch))
    else $error("single mode left selected channel");
  rr_order_a: assert property (conv_done_s and !single && s.ch == CH_VDD
      |=> o_adc_channel == CH_INT)
    else $error("round robin order broken after supply");
  irq_level_a: assert property (o_int ==
      ((|(s.flags & ~s.mask)) ? s.cfg1[CFG1_POL_BIT] : !s.cfg1[CFG1_POL_BIT]))
    else $error("interrupt level disagrees with flags");
  flag_set_a: assert property (res.chk_valid && res.chk_over && !s.mask[res.chk_ch]
      |=> s.flags[$past(res.chk_ch)])
    else $error("unmasked violation did not set flag");
  avg_len_a: assert property (s.wr_en && s.wr_ch == CH_EXT && $past(avg_on)
      |-> $past(s.avg_cnt) == AVG_LAST)
    else $error("external average not over sixteen samples");
  offset_a: assert property (s.wr_en && s.wr_ch == CH_INT
      |-> s.wr_data == 10'($past(i_adc_data) + {{2{$past(s.tofs[7])}}, $past(s.tofs)}))
    else $error("internal temperature offset not applied");
  idle_a: assert property (s.seq == SQ_IDLE && !en |=> !o_adc_start)
    else $error("conversion started while disabled");
endmodule
`default_nettype wire

// *** tb/cmlc_adc_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module cmlc_adc_model (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic i_abort,
  input wire logic [3:0] i_channel,
  output logic o_done,
  output logic [9:0] o_data
);
  // ---------------------------------------------------------------
  // converter state, per-channel sample values set by the bench
  // ---------------------------------------------------------------
  logic [9:0] vals [0:9] = '{default: 10'h000};
  logic [9:0] last2 = 10'h000;
  logic [9:0] smp;
  logic alt = 1'h0;
  logic flip = 1'h0;
  logic busy = 1'h0;
  logic [3:0] ch = 4'h0;
  int cnt = 0;

  initial begin
    o_done = 1'h0;
    o_data = 10'h155;
  end

  // ---------------------------------------------------------------
  // one done per start after a random delay, none after abort
  // ---------------------------------------------------------------
  always @(posedge i_clk) begin
    o_done <= 1'h0;
    o_data <= ~o_data;
    if (i_rst || i_abort) begin
      busy <= 1'h0;
    end else if (i_start) begin
      busy <= 1'h1;
      ch <= i_channel;
      cnt <= 2 + $urandom_range(5);
    end else if (busy && cnt == 0) begin
      smp = vals[ch] + ((alt && ch == 4'h2 && flip) ? 10'h002 : 10'h000);
      busy <= 1'h0;
      o_done <= 1'h1;
      o_data <= smp;
      if (ch == 4'h2) begin
        last2 <= smp;
        flip <= ~flip;
      end
    end else if (busy) begin
      cnt <= cnt - 1;
    end
  end
endmodule
`default_nettype wire

// *** tb/tb_channel_monitor_limit_check.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_channel_monitor_limit_check;
  import cmlc_pkg::*;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [9:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr, adc_start, adc_abort, adc_done, int_out;
  logic [3:0] adc_ch, exp_ch;
  logic [9:0] adc_data, r9;
  logic [32:0] exp_q [$];
  logic single = 1'h0;
  logic ain = 1'h1;
  logic gapchk = 1'h0;
  logic pend = 1'h0;
  logic [3:0] sel = 4'h0;
  logic [3:0] rr_next = 4'h0;
  logic [3:0] last_ch = 4'h0;
  int fails = 0;
  int tests_run = 0;
  int n_start = 0;
  int n_abort = 0;
  int base = 0;
  int ab = 0;

  always #5 clk = ~clk;

  cmlc_monitor uut (.i_sys_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .o_adc_start(adc_start),
    .o_adc_abort(adc_abort), .o_adc_channel(adc_ch), .i_adc_done(adc_done),
    .i_adc_data(adc_data), .o_int(int_out));

  cmlc_adc_model adc (.i_clk(clk), .i_rst(rst), .i_start(adc_start), .i_abort(adc_abort),
    .i_channel(adc_ch), .o_done(adc_done), .o_data(adc_data));

  // ---------------------------------------------------------------
  // compare and closing tasks
  // ---------------------------------------------------------------
  task automatic cmp_word(input logic [32:0] act, input logic [32:0] exp);
    tests_run++;
    if (act !== exp) begin
      fails++;
      $display("MISMATCH t=%0t read got %h want %h", $time, act, exp);
    end
  endtask

  task automatic cmp_sig(input logic [3:0] act, input logic [3:0] exp);
    tests_run++;
    if (act !== exp) begin
      fails++;
      $display("MISMATCH t=%0t signal got %h want %h", $time, act, exp);
    end
  endtask

  // host side conversion of degrees into the stored code
  function automatic logic [9:0] host_code(input real deg);
    if (deg >= 0.0) return 10'($rtoi(deg * 4.0));
    return 10'($rtoi(deg * 4.0) + 512) | 10'h200;
  endfunction

  task automatic tally_and_finish;
    if (fails == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // apb master
  // ---------------------------------------------------------------
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                      input logic [9:0] exp, input logic err);
    @(posedge clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= {idx, 2'h0};
    pwdata <= {24'h000000, wd};
    exp_q.push_back({err, 22'h000000, exp});
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    xfer(1'h1, idx, wd, 10'h000, 1'h0);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [9:0] exp);
    xfer(1'h0, idx, 8'h00, exp, 1'h0);
  endtask

  task automatic wait_starts(input int n);
    base = n_start;
    repeat (3000) begin
      @(negedge clk);
      if (n_start >= base + n) break;
    end
    cmp_sig({3'h0, n_start >= base + n}, 4'h1);
  endtask

  task automatic int_is(input logic lvl);
    repeat (3) @(negedge clk);
    cmp_sig({3'h0, int_out}, {3'h0, lvl});
  endtask

  // ---------------------------------------------------------------
  // output watcher
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (pready === 1'h1) begin
      if (exp_q.size() == 0) begin
        fails++;
        $display("MISMATCH t=%0t unexpected answer", $time);
      end else begin
        cmp_word({pslverr, prdata}, exp_q.pop_front());
      end
    end
    if (adc_start === 1'h1) begin
      exp_ch = single ? sel : rr_next;
      cmp_sig(adc_ch, exp_ch);
      last_ch = exp_ch;
      rr_next = (exp_ch == CH_LAST) ? 4'h0 : (exp_ch == CH_EXT && !ain) ? CH_AIN3 : exp_ch + 4'h1;
      n_start++;
    end
    if (adc_abort === 1'h1) begin
      rr_next = last_ch;
      n_abort++;
    end
    if (pend) cmp_sig({3'h0, adc_start}, 4'h1);
    pend = gapchk && adc_done === 1'h1 && psel === 1'h0;
  end

  initial begin
    repeat (50000) @(posedge clk);
    fails++;
    $display("MISMATCH t=%0t timeout", $time);
    tally_and_finish();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(7050));
    r9 = 10'h004 + 10'($urandom_range(1015));
    adc.vals[0] = 10'h204;
    adc.vals[1] = 10'h002;
    adc.vals[3] = 10'h100;
    adc.vals[9] = r9;
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    rd(IDX_CFG1, {2'h0, CFG1_RST});
    rd(IDX_CTL2, {2'h0, CTL2_RST});
    rd(IDX_UPPER_BASE, {2'h0, UPPER_RST});
    xfer(1'h0, 8'h02, 8'h00, 10'h000, 1'h1);
    wr(IDX_RES_BASE, 8'hAA);
    rd(IDX_RES_BASE, 10'h000);
    cmp_sig(4'(n_start), 4'h0);
    wr(IDX_UPPER_BASE, 8'h80);
    wr(IDX_LOWER_BASE + 8'h03, 8'h40);
    wr(IDX_TOFS, 8'hFC);
    wr(IDX_MASK1, 8'hFB);
    wr(IDX_CFG1, 8'h0B);
    wait_starts(12);
    wr(IDX_CFG1, 8'h0A);
    rd(IDX_RES_BASE, 10'h204);
    rd(IDX_RES_BASE + 8'h01, host_code(-0.5));
    rd(IDX_RES_BASE + 8'h03, 10'h100);
    rd(IDX_RES_BASE + 8'h09, r9);
    rd(IDX_STAT1, 10'h004);
    rd(IDX_STAT2, 10'h010);
    int_is(1'h1);
    wr(IDX_MASK1, 8'hFF);
    wr(IDX_MASK2, 8'hFF);
    int_is(1'h0);
    wr(IDX_MASK2, 8'h00);
    int_is(1'h1);
    wr(IDX_STAT2, 8'h10);
    rd(IDX_STAT2, 10'h000);
    int_is(1'h0);
    wr(IDX_CFG1, 8'h02);
    int_is(1'h1);
    wr(IDX_MASK1, 8'hFB);
    int_is(1'h0);
    wr(IDX_STAT1, 8'h04);
    int_is(1'h1);
    single = 1'h1;
    sel = CH_INT;
    wr(IDX_CTL2, 8'h11);
    gapchk = 1'h1;
    wr(IDX_CFG1, 8'h0B);
    wait_starts(6);
    ab = n_abort;
    rd(IDX_CTL2, 10'h011);
    cmp_sig({3'h0, n_abort > ab}, 4'h1);
    wait_starts(3);
    sel = CH_VDD;
    wr(IDX_CTL2, 8'h10);
    wait_starts(4);
    wr(IDX_CFG1, 8'h08);
    sel = CH_EXT;
    adc.vals[2] = 10'h040;
    adc.alt = 1'h1;
    wr(IDX_CTL2, 8'h12);
    wr(IDX_CFG1, 8'h09);
    wait_starts(40);
    wr(IDX_CFG1, 8'h08);
    rd(IDX_RES_BASE + 8'h02, host_code(16.25));
    wr(IDX_CTL2, 8'h32);
    wr(IDX_CFG1, 8'h09);
    wait_starts(5);
    wr(IDX_CFG1, 8'h08);
    rd(IDX_RES_BASE + 8'h02, adc.last2);
    single = 1'h0;
    ain = 1'h0;
    rr_next = CH_VDD;
    wr(IDX_CTL2, 8'h20);
    wr(IDX_CFG1, 8'h09);
    wait_starts(12);
    wr(IDX_CFG1, 8'h08);
    tally_and_finish();
  end
endmodule
`default_nettype wire
